//--- verilog/rsl_reset_core.sv
// Purpose: Gather system reset sources, sequence the hold, keep causes.
// Assumes: APB slave on MCLK; option bit, stop mode and watchdog
//   time-out come from logic on MCLK; supply, pins are asynchronous.
// Notes: Debugger control is cleared once the hold of the system reset it asks for begins.
// Contract
// - Supply low resets; delay starts after rise.
// - Watchdog time-out resets when in reset mode.
// - Pin pulses under three clocks ignored.
// - Debugger control bit zero resets system.
// - Stop mode: supply, filtered pin, debug pin.
// - Hold reset until power-on counter expires.
// - Crystal option selects longer counter time-out.
// - Fetch reset vector at 0002 on release.
// - Power-on flag readable in watchdog control.
// - External flag set by pin reset.
// - Power-on or pin wake clears external flag.
// - Status read clears external flag.
// - Reserved status bits read as zero.
// - Pin reset sets ext; watchdog sets wdt.
// - Debugger or debug pin reset sets por.
// - Pin wake sets stop; watchdog wake sets both.
`timescale 1ns/100ps
module rsl_reset_core #(
  parameter int unsigned POR_CYC_RC = rsl_pkg::POR_CYC_RC,
  parameter int unsigned POR_CYC_XTAL = rsl_pkg::POR_CYC_XTAL,
  parameter int unsigned CNT_W = 16
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic SUPPLY_OK,
  input wire logic WDT_TIMEOUT,
  input wire logic RESET_PIN_N,
  input wire logic RESET_PIN_AF_N,
  input wire logic DEBUG_PIN,
  input wire logic STOP_MODE,
  input wire logic GPIO_WAKE,
  input wire logic OPT_XTAL_EN,
  output logic SYS_RST,
  output logic FETCH_VEC,
  output logic [15:0] VEC_ADDR
);
  rsl_pkg::rsl_state_e state;
  rsl_pkg::rsl_state_e next_state;
  rsl_pkg::rsl_flags_s flags;
  rsl_pkg::rsl_flags_s next_flags;
  rsl_pkg::rsl_flags_s flags_rc;
  rsl_pkg::rsl_flags_s cause;
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [CNT_W-1:0] cnt;
  logic dbg_rst_req;
  logic wdt_rst_mode;
  logic pin_held;
  wire supply_ok_s;
  wire af_pin_n_s;
  wire dbg_pin_s;
  wire src_por;
  wire src_wdt;
  wire src_pin;
  wire src_dbgc;
  wire src_dbgp;
  wire any_src;
  wire start;
  wire rec_gpio;
  wire rec_wdt;
  wire [CNT_W-1:0] por_lim;
  wire cnt_end;
  wire acc;
  wire done;
  wire hit_stat;
  wire hit_dbg;
  wire hit_wdt;
  wire hit_any;
  wire stat_rd;
  wire dbg_wr;
  wire wdt_wr;
  wire [31:0] rd_mux;

  // Cause chosen when a sequence starts; supply and debugger rank first
  // pin cause ext
  function automatic rsl_pkg::rsl_flags_s cause_of(
    input logic por,
    input logic dbg,
    input logic pin
  );
    if (por || dbg) begin
      return rsl_pkg::FLG_POR;
    end else if (pin) begin
      return rsl_pkg::FLG_EXT;
    end
    return rsl_pkg::FLG_WDT;
  endfunction : cause_of

  // Register offset match
  function automatic logic is_ofs(
    input logic [7:0] addr,
    input logic [7:0] ofs
  );
    return addr == ofs;
  endfunction : is_ofs

  // Asynchronous levels pass two flops; the first feeds only the second
  always_ff @(posedge MCLK) begin
    if (RST) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
    end else begin
      sync1 <= {SUPPLY_OK, RESET_PIN_AF_N, DEBUG_PIN};
      sync2 <= sync1;
    end
  end
  assign supply_ok_s = sync2[2];
  assign af_pin_n_s = sync2[1];
  assign dbg_pin_s = sync2[0];

  // Digital width filter for the pin in normal and halt modes
  rsl_pin_filter #(
    .MIN_CYC(rsl_pkg::PIN_MIN_CYC)
  ) u_pin (
    .clk(MCLK),
    .rst(RST),
    .pin_n(RESET_PIN_N),
    .held(pin_held)
  );

  assign src_por = !supply_ok_s;
  assign src_wdt = WDT_TIMEOUT && wdt_rst_mode && !STOP_MODE;
  // stop mode uses the analog-filtered pin instead
  assign src_pin = STOP_MODE ? !af_pin_n_s : pin_held;
  assign src_dbgc = dbg_rst_req && !STOP_MODE;
  assign src_dbgp = STOP_MODE && !dbg_pin_s;
  assign any_src = src_por || src_wdt || src_pin || src_dbgc || src_dbgp;

  assign start = (state != rsl_pkg::ST_HOLD) && any_src;
  assign cause = cause_of(src_por, src_dbgc || src_dbgp, src_pin);

  // Stop recoveries do not reset the system, they only record the wake
  assign rec_gpio = STOP_MODE && GPIO_WAKE && (state == rsl_pkg::ST_RUN);
  assign rec_wdt = STOP_MODE && WDT_TIMEOUT && (state == rsl_pkg::ST_RUN);

  assign por_lim = OPT_XTAL_EN ? CNT_W'(POR_CYC_XTAL) : CNT_W'(POR_CYC_RC);
  assign cnt_end = cnt == por_lim - 1'b1;

  always_comb begin
    next_state = state;
    unique case (state)
      rsl_pkg::ST_HOLD: begin
        if (!any_src) next_state = rsl_pkg::ST_COUNT;
      end
      rsl_pkg::ST_COUNT: begin
        if (any_src) next_state = rsl_pkg::ST_HOLD;
        else if (cnt_end) next_state = rsl_pkg::ST_RUN;
      end
      rsl_pkg::ST_RUN: begin
        if (any_src) next_state = rsl_pkg::ST_HOLD;
      end
      default: next_state = rsl_pkg::ST_HOLD;
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      state <= rsl_pkg::ST_HOLD;
    end else begin
      state <= next_state;
    end
  end

  // count restarts whenever the hold is re-entered
  always_ff @(posedge MCLK) begin
    if (RST || state != rsl_pkg::ST_COUNT || next_state != rsl_pkg::ST_COUNT) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      SYS_RST <= 1'b1;
      FETCH_VEC <= 1'b0;
      VEC_ADDR <= rsl_pkg::RESET_VEC;
    end else begin
      SYS_RST <= next_state != rsl_pkg::ST_RUN;
      FETCH_VEC <= state == rsl_pkg::ST_COUNT && next_state == rsl_pkg::ST_RUN;
      VEC_ADDR <= rsl_pkg::RESET_VEC;
    end
  end

  // APB decode; the access phase ends one cycle after it begins
  assign acc = PSEL && PENABLE && !PREADY;
  assign done = PSEL && PENABLE && PREADY;
  assign hit_stat = is_ofs(PADDR, rsl_pkg::OFS_STATUS);
  assign hit_dbg = is_ofs(PADDR, rsl_pkg::OFS_DBGCTL);
  assign hit_wdt = is_ofs(PADDR, rsl_pkg::OFS_WATCHDOG_CONTROL_REGISTER);
  assign hit_any = hit_stat || hit_dbg || hit_wdt;
  assign stat_rd = acc && !PWRITE && hit_stat;
  assign dbg_wr = done && PWRITE && hit_dbg;
  assign wdt_wr = done && PWRITE && hit_wdt;

  assign rd_mux = hit_stat ? {24'h0, flags, rsl_pkg::STAT_RSV} :
    hit_dbg ? 32'(dbg_rst_req) << rsl_pkg::DBG_RST_BIT :
    hit_wdt ? (32'(flags.por) << rsl_pkg::WDT_POR_BIT) |
      (32'(wdt_rst_mode) << rsl_pkg::WDT_MODE_BIT) : 32'h0;

  // Read data latched at the same edge the clear acts, so no set is lost
  always_ff @(posedge MCLK) begin
    if (RST) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= acc;
      PRDATA <= (acc && !PWRITE) ? rd_mux : 32'h0;
      PSLVERR <= acc && !hit_any;
    end
  end

  assign flags_rc = stat_rd ? (flags & ~rsl_pkg::FLG_RD_CLR) : flags;
  assign next_flags = start ? cause :
    rec_gpio ? rsl_pkg::FLG_STOP :
    rec_wdt ? rsl_pkg::FLG_STOP_WDT : flags_rc;

  always_ff @(posedge MCLK) begin
    if (RST) begin
      flags <= rsl_pkg::FLG_POR;
    end else begin
      flags <= next_flags;
    end
  end

  // request cleared once the hold takes it; a new write wins
  always_ff @(posedge MCLK) begin
    if (RST) begin
      dbg_rst_req <= 1'b0;
    end else if (dbg_wr) begin
      dbg_rst_req <= PWDATA[rsl_pkg::DBG_RST_BIT];
    end else if (state == rsl_pkg::ST_HOLD) begin
      dbg_rst_req <= 1'b0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      wdt_rst_mode <= rsl_pkg::WDT_MODE_RST;
    end else if (wdt_wr) begin
      wdt_rst_mode <= PWDATA[rsl_pkg::WDT_MODE_BIT];
    end
  end

  // Release step: last hold cycle then running
  sequence s_release;
    SYS_RST ##1 !SYS_RST;
  endsequence

  a_supply_holds: assert property (@(posedge MCLK) disable iff (RST)
    src_por |-> ##1 SYS_RST ##1 (SYS_RST || !$past(src_por)))
    else $error("supply low did not hold reset");

  a_wdt_resets: assert property (@(posedge MCLK) disable iff (RST)
    src_wdt && !src_por && !src_pin && !src_dbgc && state == rsl_pkg::ST_RUN
    |-> ##1 SYS_RST && flags == rsl_pkg::FLG_WDT)
    else $error("watchdog time-out did not reset with wdt cause");

  a_dbg_resets: assert property (@(posedge MCLK) disable iff (RST)
    src_dbgc && state == rsl_pkg::ST_RUN |-> ##1 SYS_RST && flags == rsl_pkg::FLG_POR)
    else $error("debugger reset not taken");

  a_dbg_pin_stop: assert property (@(posedge MCLK) disable iff (RST)
    src_dbgp && state != rsl_pkg::ST_HOLD |-> ##1 SYS_RST && flags.por)
    else $error("debug pin low in stop did not reset");

  a_count_holds: assert property (@(posedge MCLK) disable iff (RST)
    state == rsl_pkg::ST_COUNT |-> SYS_RST)
    else $error("reset released while counting");

  a_count_length: assert property (@(posedge MCLK) disable iff (RST)
    s_release |-> $past(cnt) == $past(por_lim) - 1'b1)
    else $error("power-on count length wrong");

  a_vector_fetch: assert property (@(posedge MCLK) disable iff (RST)
    s_release |-> FETCH_VEC && VEC_ADDR == rsl_pkg::RESET_VEC ##1 !FETCH_VEC)
    else $error("reset vector fetch missing");

  a_pin_cause: assert property (@(posedge MCLK) disable iff (RST)
    src_pin && !src_por && !src_dbgc && !src_dbgp && state == rsl_pkg::ST_RUN
    |-> ##1 flags == rsl_pkg::FLG_EXT)
    else $error("pin reset did not set only ext");

  a_read_clear: assert property (@(posedge MCLK) disable iff (RST)
    stat_rd && !start |-> ##1 !flags.external_reset_flag && PRDATA[rsl_pkg::STAT_FLAG_LSB] == $past(flags.external_reset_flag))
    else $error("status read did not clear ext");

  a_rsv_zero: assert property (@(posedge MCLK) disable iff (RST)
    stat_rd |-> ##1 PRDATA[rsl_pkg::STAT_FLAG_LSB-1:0] == rsl_pkg::STAT_RSV)
    else $error("reserved status bits not zero");

  a_por_readback: assert property (@(posedge MCLK) disable iff (RST)
    acc && !PWRITE && hit_wdt |-> ##1 PRDATA[rsl_pkg::WDT_POR_BIT] == $past(flags.por))
    else $error("power-on flag not seen in watchdog control");

  a_wake_clear: assert property (@(posedge MCLK) disable iff (RST)
    rec_gpio && !start |-> ##1 flags == rsl_pkg::FLG_STOP)
    else $error("pin wake did not clear ext");

  a_stop_wake: assert property (@(posedge MCLK) disable iff (RST)
    rec_wdt && !start && !rec_gpio |-> ##1 flags == rsl_pkg::FLG_STOP_WDT)
    else $error("watchdog stop wake flags wrong");

  a_hold_all: assert property (@(posedge MCLK) disable iff (RST)
    any_src |-> ##1 state == rsl_pkg::ST_HOLD)
    else $error("hold left with a source active");
endmodule : rsl_reset_core

//--- verilog/rsl_pkg.sv
// Purpose: Shared constants and types for the reset source logic.
// Assumes: 20 MHz system clock, 32-bit APB register access.
// Notes: Flag layout follows the reset status register, bits [7:4].
package rsl_pkg;
  // Clock rate
  localparam int unsigned MCLK_MHZ = 20;
  // Register byte offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_DBGCTL = 8'h04;
  localparam logic [7:0] OFS_WATCHDOG_CONTROL_REGISTER = 8'h08;
  // Field positions
  localparam int unsigned STAT_FLAG_LSB = 4;
  localparam int unsigned DBG_RST_BIT = 0;
  localparam int unsigned WDT_MODE_BIT = 0;
  localparam int unsigned WDT_POR_BIT = 7;
  // Reset values
  localparam logic WDT_MODE_RST = 1'b1;
  localparam logic [3:0] STAT_RSV = 4'h0;
  // First word fetched once the hold ends
  localparam logic [15:0] RESET_VEC = 16'h0002;
  // Shortest external pin pulse that counts, in synchronised cycles
  localparam int unsigned PIN_MIN_CYC = 3;
  // Power-on counter time-outs, in microseconds, and their cycle counts
  localparam int unsigned POR_RC_US = 50;
  localparam int unsigned POR_XTAL_US = 500;
  localparam int unsigned POR_CYC_RC = POR_RC_US * MCLK_MHZ;
  localparam int unsigned POR_CYC_XTAL = POR_XTAL_US * MCLK_MHZ;
  // Cause flags as they sit in the status register
  typedef struct packed {
    logic por;
    logic stop;
    logic wdt;
    logic external_reset_flag;
  } rsl_flags_s;
  localparam rsl_flags_s FLG_POR = 4'h8;
  localparam rsl_flags_s FLG_STOP = 4'h4;
  localparam rsl_flags_s FLG_STOP_WDT = 4'h6;
  localparam rsl_flags_s FLG_WDT = 4'h2;
  localparam rsl_flags_s FLG_EXT = 4'h1;
  // Flags that a status read clears
  localparam rsl_flags_s FLG_RD_CLR = 4'h3;
  // Sequencer states
  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_COUNT = 2'b01,
    ST_RUN = 2'b10
  } rsl_state_e;
endpackage : rsl_pkg

//--- verilog/rsl_pin_filter.sv
// Purpose: Synchronise the external reset pin and drop short pulses.
// Assumes: Pin is asynchronous to MCLK, active low.
// Notes: Width is measured in whole synchronised cycles.
`timescale 1ns/100ps
module rsl_pin_filter #(
  parameter int unsigned MIN_CYC = rsl_pkg::PIN_MIN_CYC,
  parameter int unsigned CNT_W = $clog2(MIN_CYC + 1)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic pin_n,
  output logic held
);
  logic s1;
  logic s2;
  logic [CNT_W-1:0] low_cnt;
  wire low_long;

  always_ff @(posedge clk) begin
    if (rst) begin
      s1 <= 1'b1;
      s2 <= 1'b1;
    end else begin
      s1 <= pin_n;
      s2 <= s1;
    end
  end

  // Saturating count of earlier low samples; a glitch restarts it
  always_ff @(posedge clk) begin
    if (rst || s2) begin
      low_cnt <= '0;
    end else if (low_cnt != CNT_W'(MIN_CYC)) begin
      low_cnt <= low_cnt + 1'b1;
    end
  end

  assign low_long = !s2 && (low_cnt >= CNT_W'(MIN_CYC - 1));

  always_ff @(posedge clk) begin
    if (rst) begin
      held <= 1'b0;
    end else begin
      held <= low_long;
    end
  end

  a_pin_min_width: assert property (@(posedge clk) disable iff (rst)
    $rose(held) |-> $past(low_cnt) == CNT_W'(MIN_CYC - 1) && !$past(s2))
    else $error("pin reset taken before minimum width");

  a_pin_release: assert property (@(posedge clk) disable iff (rst)
    s2 |-> ##1 !held)
    else $error("pin reset held after synchronised release");
endmodule : rsl_pin_filter

//--- sim/rsl_far_side.sv
// Purpose: Far side of the reset block: supply monitor, reset pins, debug pin.
// Assumes: Lines change by non-blocking assignment just after MCLK rises.
// Notes: Lines idle high, as the pin pull-ups would leave them.
`timescale 1ns/100ps
module rsl_far_side (
  input wire logic clk,
  output logic supply_ok,
  output logic pin_n,
  output logic pin_af_n,
  output logic dbg_pin
);
  // Line 0 supply, 1 digital pin, 2 analog-filtered pin, 3 debug pin
  logic [3:0] line_q = 4'hF;

  // Outputs straight from the line states
  assign supply_ok = line_q[0];
  assign pin_n = line_q[1];
  assign pin_af_n = line_q[2];
  assign dbg_pin = line_q[3];

  // drivers for all four source lines
  // Hold one line low for n cycles; lines are independent so calls may overlap
  task automatic low(input int sel, input int n);
    @(posedge clk);
    line_q[sel] <= 1'b0;
    repeat (n) @(posedge clk);
    line_q[sel] <= 1'b1;
  endtask : low
endmodule : rsl_far_side

//--- sim/rsl_reset_core_test.sv
// Purpose: Self-checking bench for the reset source block.
// Assumes: Shortened power-on counts; bench is the APB master.
// Notes: Hold lengths are measured, so only their relations are checked.
`timescale 1ns/100ps
module rsl_reset_core_test;
  localparam int unsigned CYC_RC = 8;
  localparam int unsigned CYC_XTAL = 16;
  localparam int LIMIT = 20000;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, sys_rst, fetch_vec;
  logic [15:0] vec_addr;
  logic wdt_to = 1'b0;
  logic stop = 1'b0;
  logic gpio_wake = 1'b0;
  logic opt_xtal = 1'b0;
  logic supply_ok, pin_n, pin_af_n, dbg_pin;
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;
  int n_hi = 0;
  int n, m;
  int nd [2];
  logic [31:0] q;
  logic e;

  rsl_reset_core #(.POR_CYC_RC(CYC_RC), .POR_CYC_XTAL(CYC_XTAL)) i_rsl_reset_core (
    .MCLK(mclk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .SUPPLY_OK(supply_ok), .WDT_TIMEOUT(wdt_to),
    .RESET_PIN_N(pin_n), .RESET_PIN_AF_N(pin_af_n), .DEBUG_PIN(dbg_pin),
    .STOP_MODE(stop), .GPIO_WAKE(gpio_wake), .OPT_XTAL_EN(opt_xtal),
    .SYS_RST(sys_rst), .FETCH_VEC(fetch_vec), .VEC_ADDR(vec_addr));

  rsl_far_side i_rsl_far_side (.clk(mclk), .supply_ok(supply_ok), .pin_n(pin_n),
    .pin_af_n(pin_af_n), .dbg_pin(dbg_pin));

  // Clock, cycle count for the hang limit, and cycles spent in reset
  initial forever #25 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    n_hi <= n_hi + (sys_rst === 1'b1);
    if (cycles == LIMIT) begin
      fail_count++;
      test_done();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // One APB transfer; the request stands until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Transfer plus checks; write data is not compared, only the error flag
  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] exp, input logic exp_err);
    apb(wr, a, d);
    if (!wr) check(q, exp);
    check({31'h0, e}, {31'h0, exp_err});
  endtask : acc

  // Wait for the hold to start, then count it; vector fetch must come with release
  task automatic hold(output int cnt);
    cnt = 0;
    while (sys_rst !== 1'b1 && cnt < 20) begin
      @(posedge mclk);
      #1;
      cnt++;
    end
    cnt = 0;
    while (sys_rst === 1'b1) begin
      @(posedge mclk);
      #1;
      cnt++;
    end
    check(fetch_vec, 1'b1);
    check(vec_addr, rsl_pkg::RESET_VEC);
  endtask : hold

  task automatic wdt_pulse;
    @(posedge mclk);
    wdt_to <= 1'b1;
    @(posedge mclk);
    wdt_to <= 1'b0;
  endtask : wdt_pulse

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask : end_test

  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    hold(n);
    check(n >= CYC_RC, 1);
    acc(0, rsl_pkg::OFS_STATUS, 0, 32'h80, 0);
    acc(0, rsl_pkg::OFS_WATCHDOG_CONTROL_REGISTER, 0, 32'h81, 0);
    // Software keeps reserved status bits at zero
    acc(1, rsl_pkg::OFS_STATUS, 32'hF0, 0, 0);
    acc(0, rsl_pkg::OFS_STATUS, 0, 32'h80, 0);
    acc(0, 8'h0C, 0, 32'h0, 1);
    acc(1, 8'h0C, 32'h1, 0, 1);
    end_test("power_on");
    m = n_hi;
    i_rsl_far_side.low(1, 2);
    repeat (10) @(posedge mclk);
    check(n_hi - m, 0);
    i_rsl_far_side.low(1, 3);
    hold(n);
    acc(0, rsl_pkg::OFS_STATUS, 0, 32'h10, 0);
    acc(0, rsl_pkg::OFS_STATUS, 0, 32'h00, 0);
    end_test("pin");
    wdt_pulse();
    hold(n);
    acc(0, rsl_pkg::OFS_STATUS, 0, 32'h20, 0);
    acc(1, rsl_pkg::OFS_WATCHDOG_CONTROL_REGISTER, 32'h0, 0, 0);
    m = n_hi;
    wdt_pulse();
    repeat (10) @(posedge mclk);
    check(n_hi - m, 0);
    repeat (4) begin
      apb(0, rsl_pkg::OFS_STATUS, 0);
      if (q[5] === 1'b0) break;
    end
    check(q[5], 1'b0);
    acc(1, rsl_pkg::OFS_WATCHDOG_CONTROL_REGISTER, 32'h1, 0, 0);
    end_test("watchdog");
    for (int k = 0; k < 2; k++) begin
      opt_xtal <= k[0];
      acc(1, rsl_pkg::OFS_DBGCTL, 32'h1, 0, 0);
      hold(nd[k]);
      acc(0, rsl_pkg::OFS_STATUS, 0, 32'h80, 0);
      acc(0, rsl_pkg::OFS_DBGCTL, 0, 32'h0, 0);
    end
    check(nd[1] - nd[0], CYC_XTAL - CYC_RC);
    opt_xtal <= 1'b0;
    end_test("debugger");
    i_rsl_far_side.low(0, 20);
    hold(n);
    check(n >= CYC_RC, 1);
    acc(0, rsl_pkg::OFS_STATUS, 0, 32'h80, 0);
    // Pin held well past the supply: hold must outlast both
    fork
      i_rsl_far_side.low(0, 20);
      begin
        repeat (4) @(posedge mclk);
        i_rsl_far_side.low(1, 40);
      end
    join
    hold(n);
    check(n >= CYC_RC, 1);
    acc(0, rsl_pkg::OFS_STATUS, 0, 32'h80, 0);
    end_test("supply");
    i_rsl_far_side.low(1, 3);
    hold(n);
    stop <= 1'b1;
    @(posedge mclk);
    gpio_wake <= 1'b1;
    @(posedge mclk);
    gpio_wake <= 1'b0;
    acc(0, rsl_pkg::OFS_STATUS, 0, 32'h40, 0);
    m = n_hi;
    wdt_pulse();
    acc(0, rsl_pkg::OFS_STATUS, 0, 32'h60, 0);
    check(n_hi - m, 0);
    i_rsl_far_side.low(2, 4);
    hold(n);
    acc(0, rsl_pkg::OFS_STATUS, 0, 32'h10, 0);
    i_rsl_far_side.low(3, 4);
    hold(n);
    acc(0, rsl_pkg::OFS_STATUS, 0, 32'h80, 0);
    i_rsl_far_side.low(0, 4);
    hold(n);
    acc(0, rsl_pkg::OFS_STATUS, 0, 32'h80, 0);
    stop <= 1'b0;
    end_test("stop");
    test_done();
  end
endmodule : rsl_reset_core_test
